// File: pkg/pcm_tone_map.svh
`ifndef PCM_TONE_MAP_SVH
`define PCM_TONE_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define ADDR_FILTER_GAIN   5'h0a
`define ADDR_SIDETONE_GAIN 5'h0b
`define ADDR_FILTER_OPT    5'h0e
`define ADDR_CODING_LAW    5'h0f
`define ADDR_TX_PATH       5'h12
`define ADDR_RX_PATH       5'h13
`define ADDR_TONE_EN       5'h18
`define ADDR_DIG_GAIN      5'h19
`define ADDR_LOW_TONE_COEFFICIENT     5'h1a
`define ADDR_HIGH_TONE_COEFFICIENT    5'h1b

// ****************************************
// field positions and reset values
// ****************************************
`define BIT_ALAW       0
`define BIT_SIGNMAG    1
`define BIT_TX_HPF     0
`define BIT_DIAL       1
`define BIT_TX_VOICE   0
`define BIT_TX_TONE    1
`define BIT_RX_VOICE   0
`define BIT_RX_TONE    1
`define BIT_SIDETONE   2
`define BIT_LO_EN      0
`define BIT_HI_EN      1
`define BIT_TONE_ST    2
`define RST_ST_GAIN    8'h03

// ****************************************
// coding and level constants
// ****************************************
`define XOR_MU         8'h7f
`define XOR_A          8'h55
`define MU_BIAS        16'h0084
`define LIN_CLIP       16'h7f7b
`define GAIN_ODD       32'sh0000_00b5
`define GAIN_EVEN      32'sh0000_0080
`define AMP_LO_MU      16'h08b0
`define AMP_HI_MU      16'h0af0
`define AMP_LO_A       16'h0458
`define AMP_HI_A       16'h0578
`define AMP_LO_ST      16'h008c
`define AMP_HI_ST      16'h00b1
`define CODE_PZ_SM     8'h80
`define CODE_PZ_MU     8'hff
`define CODE_PZ_A      8'hd5

`endif

// File: pkg/pcm_tone_pkg.sv
package pcm_tone_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_MIX} seq_e;

    typedef struct packed {
        logic [7:0]         filt_gain;
        logic [7:0]         st_gain;
        logic [7:0]         filt_opt;
        logic [7:0]         law;
        logic [7:0]         tx_path;
        logic [7:0]         rx_path;
        logic [7:0]         tone_en;
        logic [7:0]         dig_gain;
        logic [7:0]         lo_tone_coefficient;
        logic [7:0]         hi_tone_coefficient;
        logic [7:0]         rdata;
        logic               bclk_prev;
        logic               stb_prev;
        logic [7:0]         rx_shift;
        logic [7:0]         tx_shift;
        logic [7:0]         rx_code;
        logic [7:0]         tx_code;
        logic [3:0]         bit_cnt;
        logic signed [15:0] adc_lat;
        logic signed [8:0]  lo_sin;
        logic [9:0]         lo_phase;
        logic [9:0]         hi_phase;
        seq_e               seq;
        logic signed [15:0] buf0;
        logic signed [15:0] buf1;
        logic [1:0]         buf_cnt;
    } core_s;

    typedef struct packed {
        logic [7:0] data;
    } rom_s;

endpackage

// File: pkg/tone_rom_if.sv
`timescale 1ns/10ps
interface tone_rom_if (
    input wire logic clk
);
    logic [5:0] addr;
    logic [7:0] data;
    modport core (input clk, output addr, input data);
    modport rom  (input clk, input addr, output data);
endinterface

// File: rtl/tone_sine_rom.sv
`timescale 1ns/10ps
// quarter-wave sine, 64 points, registered read
module tone_sine_rom
    import pcm_tone_pkg::*;
(
    tone_rom_if.rom port
);
    localparam logic [7:0] TABLE [64] = '{
        8'h00, 8'h06, 8'h0d, 8'h13, 8'h19, 8'h1f, 8'h25, 8'h2c,
        8'h32, 8'h38, 8'h3e, 8'h44, 8'h4a, 8'h50, 8'h56, 8'h5c,
        8'h62, 8'h67, 8'h6d, 8'h73, 8'h78, 8'h7e, 8'h83, 8'h88,
        8'h8e, 8'h93, 8'h98, 8'h9d, 8'ha2, 8'ha7, 8'hab, 8'hb0,
        8'hb4, 8'hb9, 8'hbd, 8'hc1, 8'hc5, 8'hc9, 8'hcd, 8'hd0,
        8'hd4, 8'hd7, 8'hdb, 8'hde, 8'he1, 8'he4, 8'he7, 8'he9,
        8'hec, 8'hee, 8'hf0, 8'hf2, 8'hf4, 8'hf6, 8'hf7, 8'hf9,
        8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hfe, 8'hff, 8'hff
    };

    rom_s q_reg;
    rom_s q_next;

    always_comb begin
        q_next      = q_reg;
        q_next.data = TABLE[port.addr];
    end

    always_ff @(posedge port.clk) begin
        q_reg <= q_next;
    end

    assign port.data = q_reg.data;
endmodule

// File: rtl/pcm_gain_tone_generator.sv
`timescale 1ns/10ps
`include "pcm_tone_map.svh"

module pcm_gain_tone_generator
    import pcm_tone_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        bit_clock_i,
    input  wire logic        timeslot_strobe_i,
    input  wire logic        serial_pcm_rx_i,
    output logic             serial_pcm_tx_o,
    output logic             serial_pcm_tx_oe_o,
    input  wire logic [15:0] adc_sample_i,
    input  wire logic        adc_valid_i,
    output logic      [15:0] dac_sample_o,
    output logic             dac_valid_o,
    input  wire logic        dac_ready_i,
    output logic      [2:0]  tx_filter_gain_o,
    output logic      [2:0]  rx_filter_gain_o,
    output logic      [2:0]  sidetone_gain_o,
    output logic             tx_highpass_en_o,
    output logic             dial_filter_en_o,
    output logic             sidetone_en_o,
    output logic             converter_power_o
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic signed [15:0] sat16(input logic signed [31:0] p);
        if (p > 32'sd32767)
            return 16'sh7fff;
        if (p < -32'sd32768)
            return 16'sh8000;
        return p[15:0];
    endfunction

    function automatic logic [7:0] line_code(input logic [7:0] c, input logic [7:0] law);
        if (law[`BIT_SIGNMAG])
            return c;
        return c ^ (law[`BIT_ALAW] ? `XOR_A : `XOR_MU);
    endfunction

    function automatic logic signed [15:0] expand(input logic [7:0] sm, input logic alaw);
        logic [15:0] t;
        logic [15:0] m;
        t = {8'h00, sm[3:0], 4'h0};
        if (alaw)
            m = (sm[6:4] == 3'h0) ? t + 16'h0008 : (t + 16'h0108) << (sm[6:4] - 3'h1);
        else
            m = (((t >> 1) + `MU_BIAS) << sm[6:4]) - `MU_BIAS;
        return sm[7] ? $signed(m) : -$signed(m);
    endfunction

    function automatic logic [7:0] compress(input logic signed [15:0] x, input logic alaw);
        logic [15:0] m;
        logic [15:0] s16;
        logic [2:0]  seg;
        logic [3:0]  sh;
        m = x[15] ? 16'(-x) : x;
        if (m > `LIN_CLIP)
            m = `LIN_CLIP;
        if (!alaw)
            m = m + `MU_BIAS;
        seg = 3'h0;
        for (int s = 1; s < 8; s++) begin
            if (m >= (16'h0100 << (s - 1)))
                seg = 3'(s);
        end
        sh = (alaw && seg == 3'h0) ? 4'h4 : {1'b0, seg} + 4'h3;
        s16 = m >> sh;
        return {~x[15], seg, s16[3:0]};
    endfunction

    // code 0..7 gives +3n dB, 8..15 gives -(16-n)*3 dB
    function automatic logic signed [15:0] apply_gain(input logic signed [15:0] x,
                                                      input logic [3:0] g);
        logic signed [31:0] p;
        logic [3:0]         sh;
        p  = 32'(x) * (g[0] ? `GAIN_ODD : `GAIN_EVEN);
        p  = p <<< 4;
        sh = 4'hb - {g[3], g[3:1]};
        p  = p >>> sh;
        return sat16(p);
    endfunction

    function automatic logic signed [8:0] signed_sine(input logic [7:0] d, input logic neg);
        return neg ? -$signed({1'b0, d}) : $signed({1'b0, d});
    endfunction

    function automatic logic signed [31:0] tone_val(input logic signed [8:0] s,
                                                    input logic [15:0] amp, input logic en);
        logic signed [31:0] p;
        p = 32'(s) * $signed({16'h0000, amp});
        return en ? (p >>> 8) : 32'sd0;
    endfunction

    // ****************************************
    // state and datapath
    // ****************************************
    core_s q_reg;
    core_s q_next;

    logic               bclk_fall;
    logic               stb_rise;
    logic               frame_done;
    logic               push;
    logic               pop;
    logic               alaw;
    logic [9:0]         rd_phase;
    logic signed [8:0]  hi_sin;
    logic signed [15:0] tone_tx;
    logic signed [15:0] tone_st;
    logic signed [15:0] rx_lin;
    logic signed [15:0] rx_mix;
    logic signed [15:0] rx_out;
    logic signed [15:0] tx_mix;
    logic [7:0]         tx_word;

    tone_rom_if rom (.clk(clk_sys_i));

    tone_sine_rom u_rom (
        .port(rom.rom)
    );

    assign bclk_fall  = q_reg.bclk_prev & ~bit_clock_i;
    assign stb_rise   = timeslot_strobe_i & ~q_reg.stb_prev;
    assign frame_done = bclk_fall & timeslot_strobe_i & (q_reg.bit_cnt == 4'h7);
    assign push       = (q_reg.seq == ST_MIX) && (q_reg.buf_cnt != 2'h2);
    assign pop        = dac_valid_o && dac_ready_i;
    assign alaw       = q_reg.law[`BIT_ALAW];

    // phase quadrant folds onto the quarter table
    assign rd_phase = (q_reg.seq == ST_LOW) ? q_reg.lo_phase : q_reg.hi_phase;
    assign rom.addr = rd_phase[8] ? ~rd_phase[7:2] : rd_phase[7:2];
    assign hi_sin   = signed_sine(rom.data, q_reg.hi_phase[9]);

    // network tone level with twist, 6 dB less under A-law
    assign tone_tx = sat16(tone_val(q_reg.lo_sin, alaw ? `AMP_LO_A : `AMP_LO_MU,
                                    q_reg.tone_en[`BIT_LO_EN])
                         + tone_val(hi_sin, alaw ? `AMP_HI_A : `AMP_HI_MU,
                                    q_reg.tone_en[`BIT_HI_EN]));
    assign tone_st = sat16(tone_val(q_reg.lo_sin, `AMP_LO_ST,
                                    q_reg.tone_en[`BIT_LO_EN])
                         + tone_val(hi_sin, `AMP_HI_ST, q_reg.tone_en[`BIT_HI_EN]));

    // receive: expand to linear, mix, then digital gain
    assign rx_lin = expand(line_code(q_reg.rx_code, q_reg.law), alaw);
    assign rx_mix = q_reg.tone_en[`BIT_TONE_ST] ? tone_st
                  : sat16(32'(q_reg.rx_path[`BIT_RX_VOICE] ? rx_lin : 16'sh0000)
                        + 32'(q_reg.rx_path[`BIT_RX_TONE] ? tone_tx : 16'sh0000));
    assign rx_out = apply_gain(rx_mix, q_reg.dig_gain[3:0]);

    // transmit: mix, digital gain, then compress and assign code
    assign tx_mix  = sat16(32'(q_reg.tx_path[`BIT_TX_VOICE] ? q_reg.adc_lat : 16'sh0000)
                         + 32'(q_reg.tx_path[`BIT_TX_TONE] ? tone_tx : 16'sh0000));
    assign tx_word = line_code(compress(apply_gain(tx_mix, q_reg.dig_gain[7:4]),
                                        alaw), q_reg.law);

    always_comb begin
        q_next           = q_reg;
        q_next.bclk_prev = bit_clock_i;
        q_next.stb_prev  = timeslot_strobe_i;

        // ****************************************
        // register port
        // ****************************************
        if (reg_wr_i) begin
            case (reg_addr_i)
                `ADDR_FILTER_GAIN:   q_next.filt_gain = reg_wdata_i;
                `ADDR_SIDETONE_GAIN: q_next.st_gain   = reg_wdata_i;
                `ADDR_FILTER_OPT:    q_next.filt_opt  = reg_wdata_i;
                `ADDR_CODING_LAW:    q_next.law       = reg_wdata_i;
                `ADDR_TX_PATH:       q_next.tx_path   = reg_wdata_i;
                `ADDR_RX_PATH:       q_next.rx_path   = reg_wdata_i;
                `ADDR_TONE_EN:       q_next.tone_en   = reg_wdata_i;
                `ADDR_DIG_GAIN:      q_next.dig_gain  = reg_wdata_i;
                `ADDR_LOW_TONE_COEFFICIENT:     q_next.lo_tone_coefficient  = reg_wdata_i;
                `ADDR_HIGH_TONE_COEFFICIENT:    q_next.hi_tone_coefficient  = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_FILTER_GAIN:   q_next.rdata = q_reg.filt_gain;
                `ADDR_SIDETONE_GAIN: q_next.rdata = q_reg.st_gain;
                `ADDR_FILTER_OPT:    q_next.rdata = q_reg.filt_opt;
                `ADDR_CODING_LAW:    q_next.rdata = q_reg.law;
                `ADDR_TX_PATH:       q_next.rdata = q_reg.tx_path;
                `ADDR_RX_PATH:       q_next.rdata = q_reg.rx_path;
                `ADDR_TONE_EN:       q_next.rdata = q_reg.tone_en;
                `ADDR_DIG_GAIN:      q_next.rdata = q_reg.dig_gain;
                `ADDR_LOW_TONE_COEFFICIENT:     q_next.rdata = q_reg.lo_tone_coefficient;
                `ADDR_HIGH_TONE_COEFFICIENT:    q_next.rdata = q_reg.hi_tone_coefficient;
                default:             q_next.rdata = 8'h00;
            endcase
        end

        // ****************************************
        // serial port, msb first
        // ****************************************
        if (!timeslot_strobe_i)
            q_next.bit_cnt = 4'h0;
        if (stb_rise) begin
            q_next.tx_shift = q_reg.tx_code;
        end else if (bclk_fall && timeslot_strobe_i && q_reg.bit_cnt != 4'h8) begin
            q_next.rx_shift = {q_reg.rx_shift[6:0], serial_pcm_rx_i};
            q_next.tx_shift = {q_reg.tx_shift[6:0], 1'b0};
            q_next.bit_cnt  = q_reg.bit_cnt + 4'h1;
        end
        if (frame_done)
            q_next.rx_code = {q_reg.rx_shift[6:0], serial_pcm_rx_i};
        if (adc_valid_i)
            q_next.adc_lat = $signed(adc_sample_i);

        // ****************************************
        // per-sample sequence
        // ****************************************
        case (q_reg.seq)
            ST_IDLE: begin
                if (frame_done)
                    q_next.seq = ST_LOW;
            end
            ST_LOW: begin
                q_next.seq = ST_HIGH;
            end
            ST_HIGH: begin
                q_next.lo_sin = signed_sine(rom.data, q_reg.lo_phase[9]);
                q_next.seq    = ST_MIX;
            end
            ST_MIX: begin
                // waits here while the buffer is full
                if (push) begin
                    q_next.tx_code  = tx_word;
                    q_next.lo_phase = q_reg.tone_en[`BIT_LO_EN]
                                    ? q_reg.lo_phase + {2'b00, q_reg.lo_tone_coefficient}
                                    : 10'h000;
                    q_next.hi_phase = q_reg.tone_en[`BIT_HI_EN]
                                    ? q_reg.hi_phase + {2'b00, q_reg.hi_tone_coefficient}
                                    : 10'h000;
                    q_next.seq      = ST_IDLE;
                end
            end
            default: q_next.seq = ST_IDLE;
        endcase

        // ****************************************
        // two-entry receive buffer
        // ****************************************
        case ({push, pop})
            2'b10: begin
                if (q_reg.buf_cnt == 2'h0)
                    q_next.buf0 = rx_out;
                else
                    q_next.buf1 = rx_out;
                q_next.buf_cnt = q_reg.buf_cnt + 2'h1;
            end
            2'b01: begin
                q_next.buf0    = q_reg.buf1;
                q_next.buf_cnt = q_reg.buf_cnt - 2'h1;
            end
            2'b11: begin
                q_next.buf0 = rx_out;
            end
            default: ;
        endcase

        if (srst_i) begin
            q_next         = '0;
            q_next.st_gain = `RST_ST_GAIN;
            q_next.seq     = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        q_reg <= q_next;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata_o        = q_reg.rdata;
    assign serial_pcm_tx_o    = q_reg.tx_shift[7];
    assign serial_pcm_tx_oe_o = timeslot_strobe_i & q_reg.stb_prev;
    assign dac_sample_o       = q_reg.buf0;
    assign dac_valid_o        = q_reg.buf_cnt != 2'h0;
    assign tx_filter_gain_o   = q_reg.filt_gain[2:0];
    assign rx_filter_gain_o   = q_reg.filt_gain[6:4];
    assign sidetone_gain_o    = q_reg.st_gain[2:0];
    assign tx_highpass_en_o   = q_reg.filt_opt[`BIT_TX_HPF];
    assign dial_filter_en_o   = q_reg.filt_opt[`BIT_DIAL];
    assign sidetone_en_o      = q_reg.rx_path[`BIT_SIDETONE];
    assign converter_power_o  = q_reg.tx_path[`BIT_TX_VOICE]
                              | q_reg.rx_path[`BIT_RX_VOICE];

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence s_last_bit;
        bclk_fall && timeslot_strobe_i && q_reg.bit_cnt == 4'h7 && q_reg.seq == ST_IDLE;
    endsequence

    sequence s_mix_run;
        q_reg.seq == ST_HIGH ##1 q_reg.seq == ST_MIX;
    endsequence

    property p_reset_defaults;
        @(posedge clk_sys_i) disable iff (1'b0)
        srst_i |=> !converter_power_o && !sidetone_en_o && !tx_highpass_en_o
                   && !dial_filter_en_o && !q_reg.law[`BIT_ALAW] && q_reg.dig_gain == 8'h00
                   && tx_filter_gain_o == 3'h0 && rx_filter_gain_o == 3'h0;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

    property p_tx_hpf;
        logic [7:0] v;
        (reg_wr_i && reg_addr_i == `ADDR_FILTER_OPT, v = reg_wdata_i)
            |=> tx_highpass_en_o == v[`BIT_TX_HPF];
    endproperty
    a_tx_hpf: assert property (p_tx_hpf) else $error("high-pass enable not taken");

    property p_dial;
        logic [7:0] v;
        (reg_wr_i && reg_addr_i == `ADDR_FILTER_OPT, v = reg_wdata_i)
            |=> dial_filter_en_o == v[`BIT_DIAL];
    endproperty
    a_dial: assert property (p_dial) else $error("dial filter enable not taken");

    property p_sidetone;
        logic [7:0] v;
        (reg_wr_i && reg_addr_i == `ADDR_RX_PATH, v = reg_wdata_i)
            |=> sidetone_en_o == v[`BIT_SIDETONE]
                ##1 (sidetone_en_o == v[`BIT_SIDETONE]
                     || $past(reg_wr_i && reg_addr_i == `ADDR_RX_PATH));
    endproperty
    a_sidetone: assert property (p_sidetone) else $error("sidetone enable wrong");

    property p_filt_gain;
        logic [7:0] v;
        (reg_wr_i && reg_addr_i == `ADDR_FILTER_GAIN, v = reg_wdata_i)
            |=> tx_filter_gain_o == v[2:0] && rx_filter_gain_o == v[6:4];
    endproperty
    a_filt_gain: assert property (p_filt_gain) else $error("filter gain fields wrong");

    property p_st_gain;
        logic [7:0] v;
        (reg_wr_i && reg_addr_i == `ADDR_SIDETONE_GAIN, v = reg_wdata_i)
            |=> sidetone_gain_o == v[2:0];
    endproperty
    a_st_gain: assert property (p_st_gain) else $error("sidetone gain field wrong");

    property p_phase;
        push && q_reg.tone_en[`BIT_LO_EN]
            |=> q_reg.lo_phase == 10'($past(q_reg.lo_phase) + $past(q_reg.lo_tone_coefficient));
    endproperty
    a_phase: assert property (p_phase) else $error("low phase step wrong");

    property p_single;
        push && !q_reg.tone_en[`BIT_HI_EN] |=> q_reg.hi_phase == 10'h000;
    endproperty
    a_single: assert property (p_single) else $error("disabled tone still runs");

    property p_rx_sample;
        logic [7:0] v;
        (s_last_bit, v = {q_reg.rx_shift[6:0], serial_pcm_rx_i})
            |=> q_reg.rx_code == v && q_reg.seq == ST_LOW ##1 s_mix_run;
    endproperty
    a_rx_sample: assert property (p_rx_sample) else $error("receive byte wrong");

    property p_idle_code;
        logic [7:0] v;
        (push && q_reg.tx_path[`BIT_TX_VOICE] == 1'b0
              && q_reg.tx_path[`BIT_TX_TONE] == 1'b0, v = q_reg.law)
            |=> q_reg.tx_code == (v[`BIT_SIGNMAG] ? `CODE_PZ_SM
                                : v[`BIT_ALAW] ? `CODE_PZ_A : `CODE_PZ_MU);
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("silent code wrong");

    property p_buf_stall;
        q_reg.seq == ST_MIX && q_reg.buf_cnt == 2'h2 && !dac_ready_i
            |=> q_reg.seq == ST_MIX && q_reg.buf_cnt == 2'h2;
    endproperty
    a_buf_stall: assert property (p_buf_stall) else $error("buffer overrun");

endmodule

// File: testbench/pcm_link_model.sv
`timescale 1ns/10ps
// ****
// far-end serial pcm port
// ****
module pcm_link_model (
    input  wire logic clk_i,
    input  wire logic tx_i,
    input  wire logic oe_i,
    output logic      bclk_o = 1'b0,
    output logic      stb_o  = 1'b0,
    output logic      rx_o   = 1'b0
);
    // one timeslot, msb first; bit clock idles low between frames
    task automatic frame(input logic [7:0] rx, output logic [7:0] tx);
        @(negedge clk_i);
        stb_o = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            rx_o   = rx[i];
            bclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
            // an undriven line shows the inverse of the driven bit
            tx[i]  = oe_i ? tx_i : ~tx_i;
            bclk_o = 1'b0;
            repeat (4) @(negedge clk_i);
        end
        stb_o = 1'b0;
        // released line shows the inverse of the last bit
        rx_o  = ~rx[0];
    endtask
endmodule

// File: testbench/tb_pcm_gain_tone_generator.sv
`timescale 1ns/10ps
module tb_pcm_gain_tone_generator;
    import pcm_tone_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic [4:0]  addr      = 5'h00;
    logic [7:0]  wdata     = 8'h00;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        adc_v     = 1'b0;
    logic        ready     = 1'b0;
    logic [15:0] adc       = 16'h0000;
    logic [7:0]  rdata;
    logic [15:0] dac;
    logic        dac_v, bclk, stb, rx, tx, hp, dial, st_en, conv, oe;
    logic [2:0]  txg, rxg, stg;
    int          n_fail    = 0;
    int          n_checks  = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    pcm_gain_tone_generator u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .bit_clock_i(bclk), .timeslot_strobe_i(stb), .serial_pcm_rx_i(rx),
        .serial_pcm_tx_o(tx), .serial_pcm_tx_oe_o(oe), .adc_sample_i(adc),
        .adc_valid_i(adc_v), .dac_sample_o(dac), .dac_valid_o(dac_v), .dac_ready_i(ready),
        .tx_filter_gain_o(txg), .rx_filter_gain_o(rxg), .sidetone_gain_o(stg),
        .tx_highpass_en_o(hp), .dial_filter_en_o(dial), .sidetone_en_o(st_en),
        .converter_power_o(conv));
    pcm_link_model u_far (.clk_i(clk_sys_i), .tx_i(tx), .oe_i(oe), .bclk_o(bclk), .stb_o(stb),
        .rx_o(rx));
    // ****
    // shared tasks
    // ****
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic do_reset();
        srst_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        srst_i = 1'b0;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk_sys_i);
        wr    = 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        addr = a;
        rd   = 1'b1;
        @(negedge clk_sys_i);
        rd   = 1'b0;
        d    = rdata;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        logic [7:0] d;
        do_reset();
        check({txg, rxg, stg, hp, dial, st_en, conv}, 16'h0030);
        rd_reg(5'h0f, d);
        check(d, 8'h00);
        rd_reg(5'h19, d);
        check(d, 8'h00);
    endtask
    task automatic t_regs();
        logic [4:0] map [10] = '{5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h18, 5'h19,
                                 5'h1a, 5'h1b};
        logic [7:0] d;
        foreach (map[i]) wr_reg(map[i], {3'b001, map[i]} + 8'h01);
        foreach (map[i]) begin
            rd_reg(map[i], d);
            check(d, {3'b001, map[i]} + 8'h01);
        end
        wr_reg(5'h11, 8'hff);
        rd_reg(5'h11, d);
        check(d, 8'h00);
        check({txg, rxg, stg, hp, dial, st_en, conv}, 16'h0d4f);
    endtask
    // transmit path is left off, so every law must send its positive zero code
    // an a-law zero code expands to the smallest step, +8
    task automatic t_coding(input logic [7:0] law, input logic [7:0] pz, input logic [15:0] z);
        logic [7:0] got;
        int         n;
        do_reset();
        wr_reg(5'h0f, law);
        wr_reg(5'h13, 8'h01);
        adc_v = 1'b1;
        @(negedge clk_sys_i);
        adc_v = 1'b0;
        repeat (2) begin
            u_far.frame(pz, got);
            repeat (20) @(negedge clk_sys_i);
        end
        check(got, pz);
        check(oe, 1'b0);
        ready = 1'b1;
        n = 0;
        for (int k = 0; k < 20; k++) begin
            if (dac_v === 1'b1) begin
                check(dac, z);
                n++;
            end
            @(negedge clk_sys_i);
        end
        ready = 1'b0;
        check(n[15:0], 16'h0002);
    endtask
    // +6 dB on a linear 1000h sample moves the code up one segment
    task automatic t_gain();
        logic [7:0] got;
        do_reset();
        wr_reg(5'h12, 8'h01);
        wr_reg(5'h19, 8'h20);
        adc   = 16'h1000;
        adc_v = 1'b1;
        @(negedge clk_sys_i);
        adc_v = 1'b0;
        repeat (2) begin
            u_far.frame(8'hff, got);
            repeat (20) @(negedge clk_sys_i);
        end
        adc = 16'h0000;
        check(got, 8'h9f);
    endtask
    // low tone only, one step of 59h reads sine index 22; third frame stalls in a full buffer
    task automatic t_tone(input logic [7:0] en, input logic [15:0] z);
        logic [7:0] got;
        do_reset();
        wr_reg(5'h1a, 8'h59);
        wr_reg(5'h18, en);
        wr_reg(5'h12, 8'h02);
        wr_reg(5'h13, 8'h02);
        repeat (3) begin
            u_far.frame(8'hff, got);
            repeat (20) @(negedge clk_sys_i);
        end
        check(got, 8'hcc);
        check(dac_v, 1'b1);
        ready = 1'b1;
        check(dac, 16'h0000);
        @(negedge clk_sys_i);
        check(dac, z);
        @(negedge clk_sys_i);
        ready = 1'b0;
    endtask
    initial begin
        t_reset();
        t_regs();
        t_coding(8'h00, 8'hff, 16'h0000);
        t_coding(8'h01, 8'hd5, 16'h0008);
        t_coding(8'h02, 8'h80, 16'h0000);
        t_coding(8'h03, 8'h80, 16'h0008);
        t_gain();
        t_tone(8'h01, 16'h0472);
        t_tone(8'h05, 16'h0047);
        finish_test();
    end
endmodule
